// ---- sim/cms_irq_source.sv ----
// Wakeup sources seen by the controller: interrupt pins and a bus requester
`timescale 1ns/1ps
`include "cms_params.svh"

module cms_irq_source (
  input  wire logic clk_sys,
  input  wire logic fireNmi,
  input  wire logic fireInt,
  input  wire logic wantBus,
  output logic      nmiPin,
  output logic      intPin,
  output logic      holdReqPin
);
  int nmiLeft = 0;
  int intLeft = 0;

  // Pulse widths outlast the pin synchroniser; the level pin is held past wakeup
  always @(posedge clk_sys) begin
    if (fireNmi) nmiLeft <= 6;
    else if (nmiLeft > 0) nmiLeft <= nmiLeft - 1;
    if (fireInt) intLeft <= `CMS_INT_WAKE_CLOCKS + 8;
    else if (intLeft > 0) intLeft <= intLeft - 1;
  end

  assign nmiPin     = nmiLeft > 0;
  assign intPin     = intLeft > 0;
  assign holdReqPin = wantBus;
endmodule // cms_irq_source

// ---- sim/cms_mode_standby_properties.sv ----
// Port-level assertions for the mode and standby controller
`timescale 1ns/1ps
`include "cms_params.svh"

module cms_mode_standby_properties (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic                wb_ack_o,
  input wire logic                instrDone,
  input wire cms_pkg::cms_instr_t instrKind,
  input wire logic [7:0]          instrImm,
  input wire logic [15:0]         popStatusWord,
  input wire logic                busCycle,
  input wire logic                nmiPin,
  input wire logic                intPin,
  input wire logic                holdReqPin,
  input wire logic                mode_flag,
  input wire logic                decodeLegacy,
  input wire logic                emulation_indicator_status,
  input wire logic                cpuClockEnable,
  input wire logic                holdAck,
  input wire logic                pushReq,
  input wire logic                vectorLoad,
  input wire logic [7:0]          vectorNum,
  input wire logic                resumeReq,
  input wire logic [1:0]          queue_status_outputs,
  input wire logic [2:0]          bus_status_outputs,
  input wire logic                interrupt_acknowledge_output,
  input wire logic                buffer_enable_output,
  input wire logic                buffer_direction_output,
  input wire logic                ioMemSelect,
  input wire logic                low_byte_select_output
);
  import cms_pkg::*;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic       largeSys;
  logic       lastPop;
  logic [7:0] lastImm;
  logic [3:0] quiet;

  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  // Mirror of the system-size bit, taken at the write acknowledge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) largeSys <= 1'b0;
    else if (wb_ack_o && wb_we_i && wb_adr_i == `CMS_ADR_CTRL && wb_sel_i[0])
      largeSys <= wb_dat_i[`CMS_CTRL_LARGE_BIT];
  end

  // Operands of the last instruction
  always_ff @(posedge clk_sys) begin
    if (instrDone) begin
      lastImm <= instrImm;
      lastPop <= popStatusWord[`CMS_SW_MODE_BIT];
    end
  end

  // Pin quiet time; a live wakeup pin would win over an instruction's own effect
  always_ff @(posedge clk_sys) begin
    if (!rst_n || nmiPin || intPin || holdReqPin) quiet <= 4'h0;
    else if (quiet != 4'hF) quiet <= quiet + 4'h1;
  end

  sequence sDone(cms_instr_t k);
    instrDone && cpuClockEnable && quiet > 4'h6 && instrKind == k;
  endsequence

  sequence sVec(logic [7:0] v);
    pushReq && vectorLoad && vectorNum == v;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_brk_clear: assert property (
    sDone(CMS_INSTR_BREAK_FOR_EMULATION) ##0 mode_flag |-> ##1 sVec(lastImm) ##[1:2] !mode_flag)
    else $error("break did not vector and clear mode");
  a_call_native_instr_set: assert property (
    sDone(CMS_INSTR_CALL_NATIVE) ##0 !mode_flag |-> ##1 pushReq ##[1:2] mode_flag)
    else $error("call native did not set mode");
  a_return_from_interrupt_instr_mode: assert property (
    sDone(CMS_INSTR_RETURN_FROM_INTERRUPT) |-> ##[2:3] mode_flag == lastPop)
    else $error("return did not restore mode");
  a_legacy_decode: assert property (
    decodeLegacy == !mode_flag) else $error("legacy decode disagrees with mode");
  a_emu_indicator: assert property (
    emulation_indicator_status == ($past(busCycle) && !mode_flag))
    else $error("emulation indicator wrong");
  a_halt_standby: assert property (
    sDone(CMS_INSTR_HALT) |-> ##[1:3] !cpuClockEnable) else $error("halt kept clock");
  a_large_pins: assert property (
    !cpuClockEnable && !holdAck && largeSys |->
      queue_status_outputs == 2'h0 && bus_status_outputs == 3'h7) else $error("large pins");
  a_small_pins: assert property (
    !cpuClockEnable && !holdAck && !largeSys && !$past(cpuClockEnable) && !$past(holdAck) |->
      interrupt_acknowledge_output && buffer_enable_output && $stable(buffer_direction_output)
      && $stable(ioMemSelect) && $stable(low_byte_select_output)) else $error("small pins");
  a_nmi_wake: assert property (
    !cpuClockEnable && !holdAck && $rose(nmiPin) |->
      ##[2:10] sVec(`CMS_NMI_VECTOR) ##[1:3] mode_flag) else $error("nmi wake");
  a_masked_resume: assert property (
    resumeReq |-> $stable(mode_flag) && !pushReq ##1 !pushReq) else $error("masked wake");
  a_reset_native: assert property (
    $rose(rst_n) |-> mode_flag && cpuClockEnable && !holdAck) else $error("reset state");
endmodule // cms_mode_standby_properties

// ---- sim/cms_mode_standby_tb_top.sv ----
// Self-checking bench for the mode and standby controller
`timescale 1ns/1ps
`include "cms_params.svh"

module cms_mode_standby_tb_top;
  import cms_pkg::*;

  logic        clk_sys = 1'b0;
  logic        rst_n, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, instrDone, busCycle;
  logic        nmiPin, intPin, holdReqPin, fireNmi, fireInt, wantBus, gotPush, gotRes;
  logic        coreBusLockN, coreIntAckN, coreBufEnN, coreBufDir, coreIoMem, coreLowByte;
  logic        mode_flag, decodeLegacy, emulation_indicator_status, cpuClockEnable;
  logic        holdAck, pushReq, vectorLoad, resumeReq, bus_lock_output, ioMemSelect;
  logic        interrupt_acknowledge_output, buffer_enable_output;
  logic        buffer_direction_output, low_byte_select_output;
  logic [1:0]  coreQueueStatus, queue_status_outputs;
  logic [2:0]  coreBusStatus, bus_status_outputs;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i, instrImm, intVector, vectorNum, pVec;
  logic [15:0] popStatusWord, pushWord, pWord;
  logic [31:0] wb_dat_i, wb_dat_o;
  cms_instr_t  instrKind;
  int          nErrors = 0;
  int          samplesChecked = 0;

  cms_mode_standby uut (.*);
  cms_irq_source   src (.*);

  always #5 clk_sys = ~clk_sys;

  // Core-side levels are random; standby must mask them
  always @(posedge clk_sys) begin
    {coreQueueStatus, coreBusStatus, coreBusLockN, coreIntAckN, coreBufEnN, coreBufDir,
     coreIoMem, coreLowByte} <= 11'($urandom);
  end

  // Pulses last one cycle, so they are caught here
  always @(posedge clk_sys) begin
    if (pushReq === 1'b1) begin
      gotPush <= 1'b1;
      pVec    <= vectorNum;
      pWord   <= pushWord;
    end
    if (resumeReq === 1'b1) gotRes <= 1'b1;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("errors %0d checks %0d", nErrors, samplesChecked);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic waitFor(ref logic f);
    for (int i = 0; i < 60 && f !== 1'b1; i++) @(posedge clk_sys);
    chk(32'(f), 32'h1);
    if (f !== 1'b1) end_of_test();
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      chk(32'(wb_ack_o), 32'h1);
      end_of_test();
    end
  endtask

  task automatic exec(input cms_instr_t k, input logic [15:0] pop);
    @(posedge clk_sys);
    gotPush = 1'b0;
    instrDone     <= 1'b1;
    instrKind     <= k;
    instrImm      <= 8'($urandom);
    popStatusWord <= pop;
    @(posedge clk_sys);
    instrDone <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    logic        m, big, lock;
    {rst_n, ce, wb_cyc_i, wb_stb_i, wb_we_i, instrDone, busCycle} = 7'h20;
    {fireNmi, fireInt, wantBus, gotPush, gotRes} = 5'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i, instrImm, intVector, popStatusWord} = '0;
    instrKind = CMS_INSTR_OTHER;
    void'($urandom(32'h4A03));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    wb(1'b0, `CMS_ADR_STATWORD, 32'h0, q);
    chk(32'(q[15:0]), 32'(`CMS_SW_RESET));
    wb(1'b0, 8'h0C, 32'h0, q);
    chk(q, 32'h0);
    // Break only from native code, never from a called routine
    exec(CMS_INSTR_BREAK_FOR_EMULATION, 16'h0);
    chk({pVec, 7'h0, pWord[15], 7'h0, mode_flag}, {instrImm, 16'h0100});
    chk(32'(decodeLegacy), 32'h1);
    busCycle <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(32'(emulation_indicator_status), 32'h1);
    busCycle <= 1'b0;
    exec(CMS_INSTR_CALL_NATIVE, 16'h0);
    chk({gotPush, mode_flag}, 32'h3);
    exec(CMS_INSTR_RETURN_FROM_INTERRUPT, pWord);
    chk(32'(mode_flag), 32'h0);
    exec(CMS_INSTR_RETURN_FROM_EMULATION, 16'h8000 | 16'($urandom) & 16'h01FF);
    chk(32'(mode_flag), 32'h1);
    exec(CMS_INSTR_CALL_NATIVE, 16'h0);
    chk({gotPush, mode_flag}, 32'h1);
    // Each wake kind from both modes: nmi, masked int, enabled int, reset
    for (int w = 0; w < 8; w++) begin
      m    = w[0];
      big  = 1'($urandom);
      lock = m && w[1];
      intVector <= 8'($urandom);
      wb(1'b1, `CMS_ADR_CTRL, {31'h0, big}, q);
      wb(1'b1, `CMS_ADR_STATWORD, {16'h0, m, 5'h0, w[2:1] == 2'h2, 9'h0}, q);
      if (lock) exec(CMS_INSTR_BUS_LOCK_PREFIX, 16'h0);
      exec(CMS_INSTR_HALT, 16'h0);
      chk({cpuClockEnable, mode_flag}, 32'(m));
      if (big) chk({queue_status_outputs, bus_status_outputs, bus_lock_output},
                   {2'h0, 3'h7, !lock});
      else chk({interrupt_acknowledge_output, buffer_enable_output}, 32'h3);
      if (w[2:1] == 2'h0) begin
        wantBus <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk({holdAck, cpuClockEnable}, 32'h2);
        wantBus <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk({holdAck, cpuClockEnable}, 32'h0);
        exec(CMS_INSTR_BREAK_FOR_EMULATION, 16'h0);
        chk({gotPush, mode_flag}, 32'(m));
      end
      {gotPush, gotRes} = 2'b00;
      case (w[2:1])
        2'h0: begin
          fireNmi <= 1'b1;
          @(posedge clk_sys);
          fireNmi <= 1'b0;
          waitFor(gotPush);
          chk({pVec, pWord[15]}, {`CMS_NMI_VECTOR, m});
        end
        2'h1: begin
          fireInt <= 1'b1;
          @(posedge clk_sys);
          fireInt <= 1'b0;
          waitFor(gotRes);
          chk(32'(gotPush), 32'h0);
        end
        2'h2: begin
          fireInt <= 1'b1;
          @(posedge clk_sys);
          fireInt <= 1'b0;
          waitFor(gotPush);
          chk(32'(pVec), 32'(intVector));
        end
        default: begin
          rst_n <= 1'b0;
          repeat (2) @(posedge clk_sys);
          rst_n <= 1'b1;
        end
      endcase
      repeat (30) @(posedge clk_sys);
      chk({cpuClockEnable, mode_flag}, {1'b1, m || w[2:1] != 2'h1});
      if (!w[1]) begin
        exec(CMS_INSTR_RETURN_FROM_INTERRUPT, pWord);
        chk(32'(mode_flag), 32'(m));
      end
    end
    end_of_test();
  end
endmodule // cms_mode_standby_tb_top

bind cms_mode_standby cms_mode_standby_properties chk (.*);

// ---- src/cms_mode_standby.sv ----
// Operating-mode and standby controller with Wishbone status/control registers
`timescale 1ns/1ps
`include "cms_params.svh"

// Functional notes
// - Break-for-emulation pushes state, clears mode, vectors
// - Mode zero fetches and decodes legacy code
// - Return-from-interrupt restores saved mode flag
// - Reset aborts emulation like native reset
// - Interrupts in emulation serviced natively
// - Call-native in emulation pushes, sets mode, vectors
// - Return-from-emulation pops mode one, resumes native
// - Halt enters standby keeping all state
// - Standby gates clock except hold logic
// - Hold served in standby, then back
// - Large system standby output levels fixed
// - Small system standby levels held or high
// - Control outputs inactive; exit on events (large system drives bus_lock_output low in standby after a lock prefix)
// - NMI always releases standby
// - Masked interrupt wakes without taking interrupt
// - Taken wakeup enters native mode
// - Native standby always returns native
// - Mode flag is status word top bit
// - Emulation indicator high during emulation bus cycles
// - Reset exits standby into native mode
module cms_mode_standby (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                ce,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Core instruction interface
  input  wire logic                instrDone,
  input  wire cms_pkg::cms_instr_t instrKind,
  input  wire logic [7:0]          instrImm,
  input  wire logic [15:0]         popStatusWord,
  input  wire logic [7:0]          intVector,
  input  wire logic                busCycle,
  // Pins from outside the clock domain
  input  wire logic                nmiPin,
  input  wire logic                intPin,
  input  wire logic                holdReqPin,
  // Core-side output levels while running
  input  wire logic [1:0]          coreQueueStatus,
  input  wire logic [2:0]          coreBusStatus,
  input  wire logic                coreBusLockN,
  input  wire logic                coreIntAckN,
  input  wire logic                coreBufEnN,
  input  wire logic                coreBufDir,
  input  wire logic                coreIoMem,
  input  wire logic                coreLowByte,
  // Outputs
  output logic                     mode_flag,
  output logic                     decodeLegacy,
  output logic                     emulation_indicator_status,
  output logic                     cpuClockEnable,
  output logic                     holdAck,
  output logic                     pushReq,
  output logic [15:0]              pushWord,
  output logic                     vectorLoad,
  output logic [7:0]               vectorNum,
  output logic                     resumeReq,
  output logic [1:0]               queue_status_outputs,
  output logic [2:0]               bus_status_outputs,
  output logic                     bus_lock_output,
  output logic                     interrupt_acknowledge_output,
  output logic                     buffer_enable_output,
  output logic                     buffer_direction_output,
  output logic                     ioMemSelect,
  output logic                     low_byte_select_output
);
  import cms_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [2:0] pinLevel;
  logic       nmiLevel;
  logic       intLevel;
  logic       holdLevel;
  logic       nmiLevelQ;

  cms_sync #(.WIDTH(3)) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .ce       (ce),
    .pinIn    ({holdReqPin, intPin, nmiPin}),
    .levelOut (pinLevel)
  );

  assign nmiLevel  = pinLevel[0];
  assign intLevel  = pinLevel[1];
  assign holdLevel = pinLevel[2];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cms_state_t state;
  logic [15:0] status_word;
  logic        largeSystem;
  logic        lockDecoded;
  logic        nmiPending;
  logic        ieFlag;
  logic        nmiEdge;
  logic        intTake;
  logic        takeIrq;
  logic        wbReq;
  logic        wbWrite;

  assign ieFlag  = status_word[`CMS_SW_IE_BIT];
  assign nmiEdge = nmiLevel & ~nmiLevelQ;
  assign intTake = intLevel & ieFlag;
  // Interrupts are taken at an instruction boundary, or at once from standby
  assign takeIrq = (nmiPending | intTake) &
                   (((state == CMS_RUN) & instrDone) | (state == CMS_STANDBY));
  assign wbReq   = wb_cyc_i & wb_stb_i;
  assign wbWrite = wbReq & wb_we_i & wb_ack_o;

  // NMI edge detect on the filtered level
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nmiLevelQ <= 1'b0;
    end else if (ce) begin
      nmiLevelQ <= nmiLevel;
    end
  end

  // NMI request latch; a new edge wins over the clear of service
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nmiPending <= 1'b0;
    end else if (ce) begin
      if (nmiEdge) begin
        nmiPending <= 1'b1;
      end else if (takeIrq) begin
        nmiPending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word and mode flag
  // ----------------------------------------------------------------
  // Reset loads native mode whatever was running or halted
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      status_word <= `CMS_SW_RESET;
    end else if (ce) begin
      if (takeIrq) begin
        status_word[`CMS_SW_MODE_BIT] <= 1'b1;
        status_word[`CMS_SW_IE_BIT]   <= 1'b0;
      end else if (wbWrite && wb_adr_i == `CMS_ADR_STATWORD) begin
        if (wb_sel_i[0]) begin
          status_word[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          status_word[15:8] <= wb_dat_i[15:8];
        end
      end else if (state == CMS_RUN && instrDone) begin
        unique case (instrKind)
          CMS_INSTR_BREAK_FOR_EMULATION: begin
            // Nesting from a called native routine is left to software
            status_word[`CMS_SW_MODE_BIT] <= 1'b0;
          end
          CMS_INSTR_RETURN_FROM_INTERRUPT: begin
            status_word <= popStatusWord;
          end
          CMS_INSTR_CALL_NATIVE: begin
            if (!status_word[`CMS_SW_MODE_BIT]) begin
              status_word[`CMS_SW_MODE_BIT] <= 1'b1;
            end
          end
          CMS_INSTR_RETURN_FROM_EMULATION: begin
            if (!status_word[`CMS_SW_MODE_BIT]) begin
              status_word <= popStatusWord;
            end
          end
          CMS_INSTR_HALT, CMS_INSTR_BUS_LOCK_PREFIX, CMS_INSTR_OTHER: begin
            status_word <= status_word;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Push and vector requests towards the core
  // ----------------------------------------------------------------
  // One-cycle pulses; the pushed word carries the mode before the change
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pushReq    <= 1'b0;
      pushWord   <= 16'h0000;
      vectorLoad <= 1'b0;
      vectorNum  <= 8'h00;
    end else if (ce) begin
      pushReq    <= 1'b0;
      vectorLoad <= 1'b0;
      if (takeIrq) begin
        pushReq    <= 1'b1;
        pushWord   <= status_word;
        vectorLoad <= 1'b1;
        vectorNum  <= nmiPending ? `CMS_NMI_VECTOR : intVector;
      end else if (state == CMS_RUN && instrDone &&
                   (instrKind == CMS_INSTR_BREAK_FOR_EMULATION ||
                    (instrKind == CMS_INSTR_CALL_NATIVE &&
                     !status_word[`CMS_SW_MODE_BIT]))) begin
        pushReq    <= 1'b1;
        pushWord   <= status_word;
        vectorLoad <= 1'b1;
        vectorNum  <= instrImm;
      end
    end
  end

  // ----------------------------------------------------------------
  // Standby sequencer
  // ----------------------------------------------------------------
  // Masked interrupt wakes without service; the source keeps it long
  // enough for the following instruction to run
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state     <= CMS_RUN;
      resumeReq <= 1'b0;
    end else if (ce) begin
      resumeReq <= 1'b0;
      unique case (state)
        CMS_RUN: begin
          if (instrDone && instrKind == CMS_INSTR_HALT && !takeIrq) begin
            state <= CMS_STANDBY;
          end
        end
        CMS_STANDBY: begin
          if (takeIrq) begin
            state <= CMS_RUN;
          end else if (intLevel) begin
            state     <= CMS_RUN;
            resumeReq <= 1'b1;
          end else if (holdLevel) begin
            state <= CMS_HOLD;
          end
        end
        CMS_HOLD: begin
          if (!holdLevel) begin
            state <= CMS_STANDBY;
          end
        end
      endcase
    end
  end

  // Bus-lock prefix seen before the halt is remembered for standby levels
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lockDecoded <= 1'b0;
    end else if (ce && state == CMS_RUN && instrDone) begin
      lockDecoded <= (instrKind == CMS_INSTR_BUS_LOCK_PREFIX) |
                     (lockDecoded & instrKind == CMS_INSTR_HALT);
    end else if (ce && state == CMS_STANDBY && (takeIrq || intLevel)) begin
      lockDecoded <= 1'b0; // A later halt needs its own prefix
    end
  end

  // ----------------------------------------------------------------
  // Mode and clock outputs
  // ----------------------------------------------------------------
  // Clock stays gated in hold too; hold logic itself runs on clk_sys
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_flag                  <= 1'b1;
      decodeLegacy               <= 1'b0;
      emulation_indicator_status <= 1'b0;
      cpuClockEnable             <= 1'b1;
      holdAck                    <= 1'b0;
    end else if (ce) begin
      mode_flag      <= status_word[`CMS_SW_MODE_BIT];
      decodeLegacy   <= ~status_word[`CMS_SW_MODE_BIT];
      emulation_indicator_status <= busCycle & ~status_word[`CMS_SW_MODE_BIT];
      cpuClockEnable <= (state == CMS_RUN);
      holdAck        <= (state == CMS_HOLD);
    end
  end

  // ----------------------------------------------------------------
  // Pin levels during standby
  // ----------------------------------------------------------------
  // Static pins simply stop updating, which holds their last level
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      queue_status_outputs         <= 2'h0;
      bus_status_outputs           <= 3'h7;
      bus_lock_output              <= 1'b1;
      interrupt_acknowledge_output <= 1'b1;
      buffer_enable_output         <= 1'b1;
      buffer_direction_output      <= 1'b0;
      ioMemSelect                  <= 1'b0;
      low_byte_select_output       <= 1'b0;
    end else if (ce) begin
      if (state != CMS_RUN) begin
        if (largeSystem) begin
          queue_status_outputs <= 2'h0;
          bus_status_outputs   <= 3'h7;
          bus_lock_output      <= ~lockDecoded;
        end else begin
          interrupt_acknowledge_output <= 1'b1;
          buffer_enable_output         <= 1'b1;
        end
      end else begin
        queue_status_outputs         <= coreQueueStatus;
        bus_status_outputs           <= coreBusStatus;
        bus_lock_output              <= coreBusLockN;
        interrupt_acknowledge_output <= coreIntAckN;
        buffer_enable_output         <= coreBufEnN;
        buffer_direction_output      <= coreBufDir;
        ioMemSelect                  <= coreIoMem;
        low_byte_select_output       <= coreLowByte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Configuration bit written by software
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      largeSystem <= `CMS_CTRL_RESET;
    end else if (ce && wbWrite && wb_adr_i == `CMS_ADR_CTRL && wb_sel_i[0]) begin
      largeSystem <= wb_dat_i[`CMS_CTRL_LARGE_BIT];
    end
  end

  // Ack one cycle after the request, dropped the cycle after; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wbReq & ~wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wbReq && !wb_ack_o) begin
        unique case (wb_adr_i)
          `CMS_ADR_CTRL: begin
            wb_dat_o[`CMS_CTRL_LARGE_BIT] <= largeSystem;
          end
          `CMS_ADR_STATUS: begin
            wb_dat_o[`CMS_ST_MODE_BIT]    <= status_word[`CMS_SW_MODE_BIT];
            wb_dat_o[`CMS_ST_STANDBY_BIT] <= (state != CMS_RUN);
            wb_dat_o[`CMS_ST_HOLD_BIT]    <= (state == CMS_HOLD);
            wb_dat_o[`CMS_ST_LOCK_BIT]    <= lockDecoded;
            wb_dat_o[`CMS_ST_NMIP_BIT]    <= nmiPending;
          end
          `CMS_ADR_STATWORD: begin
            wb_dat_o[15:0] <= status_word;
          end
          default: begin
            wb_dat_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule // cms_mode_standby

// ---- src/cms_params.svh ----
// Offsets, field positions, reset values and timing counts of the mode/standby controller
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH

// Wishbone register byte offsets
`define CMS_ADR_CTRL       8'h00
`define CMS_ADR_STATUS     8'h04
`define CMS_ADR_STATWORD   8'h08

// Control register fields
`define CMS_CTRL_LARGE_BIT 0

// Status register fields
`define CMS_ST_MODE_BIT    0
`define CMS_ST_STANDBY_BIT 1
`define CMS_ST_HOLD_BIT    2
`define CMS_ST_LOCK_BIT    3
`define CMS_ST_NMIP_BIT    4

// Status word fields
`define CMS_SW_MODE_BIT    15
`define CMS_SW_IE_BIT      9

// Reset values and NMI vector
`define CMS_SW_RESET       16'h8000
`define CMS_CTRL_RESET     1'b0
`define CMS_NMI_VECTOR     8'h02

// Wakeup hold time that the interrupt source must keep, in clocks
`define CMS_INT_WAKE_CLOCKS 15

`endif

// ---- src/cms_pkg.sv ----
// Types shared by the mode/standby controller
package cms_pkg;

  // Instruction completed by the core, as seen by this block
  typedef enum logic [2:0] {
    CMS_INSTR_OTHER,
    CMS_INSTR_BREAK_FOR_EMULATION,
    CMS_INSTR_RETURN_FROM_INTERRUPT,
    CMS_INSTR_CALL_NATIVE,
    CMS_INSTR_RETURN_FROM_EMULATION,
    CMS_INSTR_HALT,
    CMS_INSTR_BUS_LOCK_PREFIX
  } cms_instr_t;

  // Operating state of the standby sequencer
  typedef enum logic [1:0] {
    CMS_RUN,
    CMS_STANDBY,
    CMS_HOLD
  } cms_state_t;

endpackage : cms_pkg

// ---- src/cms_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module cms_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);

  // ----------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------
  initial begin
    if (WIDTH < 1) begin
      $error("cms_sync: WIDTH must be at least 1");
    end
  end

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      logic stage1;
      logic stage2;
      logic stage3;
      // Stage one is read only by stage two; the filter looks at two and three
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          stage1      <= 1'b0;
          stage2      <= 1'b0;
          stage3      <= 1'b0;
          levelOut[b] <= 1'b0;
        end else if (ce) begin
          stage1 <= pinIn[b];
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3) begin
            levelOut[b] <= stage3; // Change counts only once two stages agree
          end
        end
      end
    end
  endgenerate

endmodule // cms_sync
